// File: hdl/mms_status_top.sv
// maximum-mode queue status, bus cycle status and halt state
`timescale 1ns/1ns
`include "mms_defines.svh"
module mms_status_top
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic max_mode,
   input wire mms_pkg::mms_qop_t queue_op,
   input wire mms_pkg::mms_bc_t cycle_req,
   input wire logic cycle_start,
   input wire mms_pkg::mms_seg_t seg_sel,
   input wire logic intr_flag,
   input wire logic stop_instruction,
   input wire logic intr_recognised,
   input wire logic hold_req,
   input wire logic rq_gt_req0,
   input wire logic rq_gt_req1,
   output logic queue_state_lo,
   output logic queue_state_hi,
   output logic cycle_type_bit0,
   output logic cycle_type_bit1,
   output logic cycle_type_bit2,
   output logic segment_ind_lo,
   output logic segment_ind_hi,
   output logic intr_enable_mirror,
   output logic fixed_zero_status,
   output logic spare_status,
   output logic halted,
   output logic exec_enable,
   output logic hold_ack,
   output logic rq_gt_grant0,
   output logic rq_gt_grant1,
   output logic status_oe
);
   import mms_pkg::*;

   typedef enum logic {MMS_RUN, MMS_HALTED} mms_state_t;

   mms_state_t state;
   mms_state_t next_state;
   logic [1:0] qs;
   logic [1:0] next_qs;
   logic [2:0] ct;
   logic [2:0] next_ct;
   logic [1:0] seg;
   logic [1:0] next_seg;
   logic ie;
   logic next_ie;
   logic halt_cycle_pending;
   logic next_halt_cycle_pending;
   mms_hold_if hif0 ();
   mms_hold_if hif1 ();
   mms_hold_if hif2 ();

   function automatic logic [1:0] qop_code(input mms_qop_t op);
      case (op)
         MMS_QOP_FIRST: qop_code = `MMS_Q_FIRST;
         MMS_QOP_FLUSH: qop_code = `MMS_Q_FLUSH;
         MMS_QOP_NEXT: qop_code = `MMS_Q_NEXT;
         default: qop_code = `MMS_Q_IDLE;
      endcase
   endfunction : qop_code

   function automatic logic [2:0] bc_code(input mms_bc_t bc);
      case (bc)
         MMS_BC_INTA: bc_code = `MMS_CT_INTA;
         MMS_BC_IORD: bc_code = `MMS_CT_IORD;
         MMS_BC_IOWR: bc_code = `MMS_CT_IOWR;
         MMS_BC_FETCH: bc_code = `MMS_CT_FETCH;
         MMS_BC_MEMRD: bc_code = `MMS_CT_MEMRD;
         MMS_BC_MEMWR: bc_code = `MMS_CT_MEMWR;
         default: bc_code = `MMS_CT_PASSIVE;
      endcase
   endfunction : bc_code

   function automatic logic [1:0] seg_code(input mms_seg_t s);
      case (s)
         MMS_SG_EXTRA: seg_code = `MMS_SEG_EXTRA;
         MMS_SG_STACK: seg_code = `MMS_SEG_STACK;
         MMS_SG_DATA: seg_code = `MMS_SEG_DATA;
         default: seg_code = `MMS_SEG_CODE;
      endcase
   endfunction : seg_code

   always_comb
   begin
      next_state = state;
      next_halt_cycle_pending = 1'b0;
      case (state)
         MMS_RUN:
         begin
            if (stop_instruction)
            begin
               next_state = MMS_HALTED;
               next_halt_cycle_pending = 1'b1;
            end
         end
         MMS_HALTED:
         begin
            if (intr_recognised)
            begin
               next_state = MMS_RUN;
            end
         end
         default: next_state = MMS_RUN;
      endcase
   end

   always_comb
   begin
      // queue events are reported one clock late, held for a full clock
      next_qs = `MMS_Q_IDLE;
      if (max_mode && state == MMS_RUN)
      begin
         next_qs = qop_code(queue_op);
      end
      next_ct = `MMS_CT_PASSIVE;
      next_seg = seg;
      // a pending halt cycle wins over a cycle start in the same clock
      if (max_mode && halt_cycle_pending)
      begin
         next_ct = `MMS_CT_HALT;
         next_seg = `MMS_SEG_CODE;
      end
      else if (max_mode && cycle_start && state == MMS_RUN)
      begin
         next_ct = bc_code(cycle_req);
         next_seg = seg_code(seg_sel);
      end
      next_ie = intr_flag;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= MMS_RUN;
         halt_cycle_pending <= 1'b0;
         qs <= `MMS_Q_IDLE;
         ct <= `MMS_CT_PASSIVE;
         seg <= `MMS_SEG_CODE;
         ie <= 1'b0;
      end
      else
      begin
         state <= next_state;
         halt_cycle_pending <= next_halt_cycle_pending;
         qs <= next_qs;
         ct <= next_ct;
         seg <= next_seg;
         ie <= next_ie;
      end
   end

   // one arbiter per hold source; none of them looks at the halt state
   assign hif0.req = hold_req & ~max_mode;
   assign hif1.req = rq_gt_req0 & max_mode;
   assign hif2.req = rq_gt_req1 & max_mode;
   mms_hold_arb u_arb0 (.clk(clk), .sys_rst(sys_rst), .hold(hif0.ctrl));
   mms_hold_arb u_arb1 (.clk(clk), .sys_rst(sys_rst), .hold(hif1.ctrl));
   mms_hold_arb u_arb2 (.clk(clk), .sys_rst(sys_rst), .hold(hif2.ctrl));
   assign hold_ack = hif0.grant;
   assign rq_gt_grant0 = hif1.grant;
   assign rq_gt_grant1 = hif2.grant;

   assign queue_state_lo = qs[0];
   assign queue_state_hi = qs[1];
   assign cycle_type_bit0 = ct[0];
   assign cycle_type_bit1 = ct[1];
   assign cycle_type_bit2 = ct[2];
   assign segment_ind_lo = seg[0];
   assign segment_ind_hi = seg[1];
   assign intr_enable_mirror = ie;
   assign fixed_zero_status = 1'b0;
   // spare line carries no meaning; held low so it is never unknown
   assign spare_status = 1'b0;
   assign halted = (state == MMS_HALTED);
   assign exec_enable = (state == MMS_RUN);
   // nothing floats, halted or not
   assign status_oe = 1'b1;

   queue_code_a: assert property (@(posedge clk) disable iff (sys_rst)
      (max_mode && state == MMS_RUN && queue_op == MMS_QOP_FLUSH) |=> qs == 2'h1)
      else $error("flush not reported");
   queue_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      (max_mode && state == MMS_RUN && queue_op == MMS_QOP_FIRST) |=> qs == 2'h2)
      else $error("first byte not reported");
   queue_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == MMS_HALTED) |=> qs == 2'h0) else $error("queue active in halt");
   min_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
      !max_mode |=> qs == 2'h0 && ct == 3'h7) else $error("status active in min mode");
   halt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (halted && !intr_recognised) |=> halted) else $error("halt left early");
   halt_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
      (halted && intr_recognised) |=> exec_enable) else $error("halt not left");
   halt_code_a: assert property (@(posedge clk) disable iff (sys_rst)
      (max_mode && state == MMS_RUN && stop_instruction) |=> ##1 ct == 3'h3)
      else $error("halt code missing");
   cycle_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!cycle_start && !halt_cycle_pending) |=> ct == 3'h7) else $error("passive code missing");
   fetch_code_a: assert property (@(posedge clk) disable iff (sys_rst)
      (max_mode && cycle_start && state == MMS_RUN && !halt_cycle_pending && cycle_req == MMS_BC_FETCH)
      |=> ct == 3'h4 && seg == $past(seg_code(seg_sel))) else $error("fetch status wrong");
   seg_stack_a: assert property (@(posedge clk) disable iff (sys_rst)
      (max_mode && cycle_start && state == MMS_RUN && !halt_cycle_pending && seg_sel == MMS_SG_STACK)
      |=> seg == 2'h1) else $error("stack segment wrong");
   // the mirror is forced low in reset, so the first clock after release is skipped
   ie_mirror_a: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> intr_enable_mirror == $past(intr_flag)) else $error("ie mirror wrong");
   zero_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
      !fixed_zero_status && status_oe) else $error("fixed bit or drive lost");
   halt_grant_a: assert property (@(posedge clk) disable iff (sys_rst)
      (halted && max_mode && rq_gt_req0) |=> rq_gt_grant0) else $error("no grant in halt");

   halt_cover: cover property (@(posedge clk) halted ##1 !halted);
   flush_cover: cover property (@(posedge clk) qs == 2'h1);
   next_cover: cover property (@(posedge clk) qs == 2'h2 ##1 qs == 2'h3);
   hold_halt_cover: cover property (@(posedge clk) halted && hold_ack);
   min_hold_cover: cover property (@(posedge clk) !max_mode && hold_ack);
endmodule : mms_status_top

// File: shared/mms_defines.svh
// constants for the maximum-mode status outputs
// Notes on behaviour
// - max mode drives two queue status outputs
// - queue codes: none, first, flush, subsequent
// - halt stops processing until interrupt or reset
// - outputs stay driven while halted
// - hold requests granted while halted too
// - three-bit bus cycle type code per cycle
// - two-bit segment indicator for current address
// - one status bit mirrors interrupt enable
// - seventh status bit zero, eighth is spare
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH
// queue codes pack {hi, lo}; lo is the first status line
`define MMS_Q_IDLE 2'h0
`define MMS_Q_FIRST 2'h2
`define MMS_Q_FLUSH 2'h1
`define MMS_Q_NEXT 2'h3
`define MMS_CT_INTA 3'h0
`define MMS_CT_IORD 3'h1
`define MMS_CT_IOWR 3'h2
`define MMS_CT_HALT 3'h3
`define MMS_CT_FETCH 3'h4
`define MMS_CT_MEMRD 3'h5
`define MMS_CT_MEMWR 3'h6
`define MMS_CT_PASSIVE 3'h7
`define MMS_SEG_EXTRA 2'h0
`define MMS_SEG_STACK 2'h1
`define MMS_SEG_CODE 2'h2
`define MMS_SEG_DATA 2'h3
`endif

// File: shared/mms_pkg.sv
// types for the maximum-mode status outputs
package mms_pkg;
   typedef enum logic [1:0] {MMS_QOP_NONE, MMS_QOP_FIRST, MMS_QOP_FLUSH, MMS_QOP_NEXT} mms_qop_t;
   typedef enum logic [2:0] {MMS_BC_INTA, MMS_BC_IORD, MMS_BC_IOWR, MMS_BC_FETCH, MMS_BC_MEMRD,
      MMS_BC_MEMWR, MMS_BC_NONE} mms_bc_t;
   typedef enum logic [1:0] {MMS_SG_EXTRA, MMS_SG_STACK, MMS_SG_CODE, MMS_SG_DATA} mms_seg_t;
endpackage : mms_pkg

// File: shared/mms_hold_if.sv
// hold request and grant signals between status top and hold arbiter
`timescale 1ns/1ns
interface mms_hold_if;
   logic req;
   logic grant;
   modport ctrl (input req, output grant);
   modport user (output req, input grant);
endinterface : mms_hold_if

// File: hdl/mms_hold_arb.sv
// bus hold arbiter, same behaviour running or halted
`timescale 1ns/1ns
module mms_hold_arb
(
   input wire logic clk,
   input wire logic sys_rst,
   mms_hold_if.ctrl hold
);
   logic grant;
   logic next_grant;

   always_comb
   begin
      // grant follows request independent of halt state
      next_grant = hold.req;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         grant <= 1'b0;
      end
      else
      begin
         grant <= next_grant;
      end
   end

   assign hold.grant = grant;

   hold_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      hold.req |=> hold.grant) else $error("hold not granted");
endmodule : mms_hold_arb

// File: verif/mms_partner.sv
// partner model: bus controller requests and escape-tracking coprocessor
`timescale 1ns/1ns
module mms_partner
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic want0,
   input wire logic want1,
   input wire logic esc_byte,
   input wire logic [1:0] qs,
   input wire logic [2:0] ct,
   output logic rq_gt_req0,
   output logic rq_gt_req1,
   output logic [3:0] esc_runs
);
   logic armed;
   assign rq_gt_req0 = want0;
   assign rq_gt_req1 = want1;
   // falling edge, so the registered status has settled
   always @(negedge clk)
   begin
      if (sys_rst)
      begin
         armed <= 1'b0;
         esc_runs <= 4'h0;
      end
      else if (ct == 3'h4 && esc_byte)
         armed <= 1'b1;
      else if (armed && qs == 2'h2)
      begin
         armed <= 1'b0;
         esc_runs <= esc_runs + 4'h1;
      end
      else if (armed && qs == 2'h1)
         armed <= 1'b0;
   end
endmodule : mms_partner

// File: verif/testbench.sv
// self-checking bench for the maximum-mode status outputs
`timescale 1ns/1ns
module testbench;
   import mms_pkg::*;
   logic clk, sys_rst, max_mode, cycle_start, intr_flag, stop_instruction, intr_recognised, hold_req;
   logic want0, want1, esc_byte, rq_gt_req0, rq_gt_req1, rq_gt_grant0, rq_gt_grant1, status_oe, hold_ack;
   logic queue_state_lo, queue_state_hi, cycle_type_bit0, cycle_type_bit1, cycle_type_bit2, segment_ind_lo;
   logic segment_ind_hi, intr_enable_mirror, fixed_zero_status, spare_status, halted, exec_enable;
   logic [3:0] esc_runs;
   mms_qop_t queue_op;
   mms_bc_t cycle_req;
   mms_seg_t seg_sel;
   int bad_count = 0;
   int samples_checked = 0;
   wire [1:0] qs = {queue_state_hi, queue_state_lo};
   wire [2:0] ct = {cycle_type_bit2, cycle_type_bit1, cycle_type_bit0};
   wire [1:0] sg = {segment_ind_hi, segment_ind_lo};
   mms_status_top i_dut (.clk, .sys_rst, .max_mode, .queue_op, .cycle_req, .cycle_start, .seg_sel, .intr_flag,
      .stop_instruction, .intr_recognised, .hold_req, .rq_gt_req0, .rq_gt_req1, .queue_state_lo, .queue_state_hi,
      .cycle_type_bit0, .cycle_type_bit1, .cycle_type_bit2, .segment_ind_lo, .segment_ind_hi, .intr_enable_mirror,
      .fixed_zero_status, .spare_status, .halted, .exec_enable, .hold_ack, .rq_gt_grant0, .rq_gt_grant1, .status_oe);
   mms_partner i_partner (.clk, .sys_rst, .want0, .want1, .esc_byte, .qs, .ct, .rq_gt_req0, .rq_gt_req1, .esc_runs);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_ct(input logic [2:0] exp, input int n);
      for (int i = 0; i < n && ct !== exp; i++)
         step();
      chk({1'h0, ct}, {1'h0, exp});
   endtask : wait_ct
   task automatic t_queue;
      // {hi, lo}: first byte is hi alone, flush is lo alone
      logic [3:0] qexp[4] = '{4'h0, 4'h2, 4'h1, 4'h3};
      for (int i = 0; i < 4; i++)
      begin
         queue_op = mms_qop_t'(i);
         step();
         chk({2'h0, qs}, qexp[i]);
      end
      max_mode = 1'b0;
      cycle_start = 1'b1;
      cycle_req = MMS_BC_MEMRD;
      want0 = 1'b1;
      step();
      chk({2'h0, qs}, 4'h0);
      chk({1'h0, ct}, 4'h7);
      chk({3'h0, rq_gt_grant0}, 4'h0);
      max_mode = 1'b1;
      cycle_start = 1'b0;
      want0 = 1'b0;
      queue_op = MMS_QOP_NONE;
      step();
   endtask : t_queue
   task automatic t_cycle;
      mms_bc_t kinds[6] = '{MMS_BC_INTA, MMS_BC_IORD, MMS_BC_IOWR, MMS_BC_FETCH, MMS_BC_MEMRD, MMS_BC_MEMWR};
      logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
      for (int i = 0; i < 6; i++)
      begin
         cycle_start = 1'b1;
         cycle_req = kinds[i];
         seg_sel = mms_seg_t'(i % 4);
         intr_flag = i[0];
         step();
         chk({1'h0, ct}, codes[i]);
         chk({2'h0, sg}, 4'(i % 4));
         chk({3'h0, intr_enable_mirror}, {3'h0, i[0]});
      end
      cycle_start = 1'b0;
      step();
      chk({1'h0, ct}, 4'h7);
      chk({2'h0, sg}, 4'h1);
      chk({2'h0, fixed_zero_status, spare_status}, 4'h0);
   endtask : t_cycle
   task automatic t_halt;
      stop_instruction = 1'b1;
      step();
      stop_instruction = 1'b0;
      wait_ct(3'h3, 3);
      chk({2'h0, sg}, 4'h2);
      cycle_start = 1'b1;
      queue_op = MMS_QOP_FIRST;
      want0 = 1'b1;
      step(2);
      chk({qs, ct[1], ct[0]}, 4'h3);
      chk({halted, exec_enable, status_oe, rq_gt_grant0}, 4'hb);
      want0 = 1'b0;
      want1 = 1'b1;
      step(2);
      chk({2'h0, rq_gt_grant0, rq_gt_grant1}, 4'h1);
      want1 = 1'b0;
      max_mode = 1'b0;
      hold_req = 1'b1;
      step(2);
      chk({3'h0, hold_ack}, 4'h1);
      hold_req = 1'b0;
      max_mode = 1'b1;
      cycle_start = 1'b0;
      queue_op = MMS_QOP_NONE;
      intr_recognised = 1'b1;
      step();
      intr_recognised = 1'b0;
      step(2);
      chk({2'h0, halted, exec_enable}, 4'h1);
   endtask : t_halt
   task automatic t_esc;
      // a flushed escape must not count, a first-byte take must
      for (int k = 0; k < 2; k++)
      begin
         cycle_start = 1'b1;
         cycle_req = MMS_BC_FETCH;
         esc_byte = 1'b1;
         step();
         cycle_start = 1'b0;
         queue_op = k ? MMS_QOP_FIRST : MMS_QOP_FLUSH;
         step();
         esc_byte = 1'b0;
         queue_op = MMS_QOP_NONE;
         step();
      end
      chk(esc_runs, 4'h1);
   endtask : t_esc
   task automatic t_reset;
      // halt is also left by a system reset in mid-run
      stop_instruction = 1'b1;
      step();
      stop_instruction = 1'b0;
      step(2);
      chk({2'h0, halted, exec_enable}, 4'h2);
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      chk({2'h0, halted, exec_enable}, 4'h1);
      chk({qs, ct[1], ct[0]}, 4'h3);
      step();
      // interrupt flag has been left high since the cycle scenario
      chk({3'h0, intr_enable_mirror}, 4'h1);
   endtask : t_reset
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   initial
   begin
      #20000;
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
   initial
   begin
      {sys_rst, max_mode} = 2'h3;
      {cycle_start, intr_flag, stop_instruction, intr_recognised, hold_req, want0, want1, esc_byte} = 8'h00;
      queue_op = MMS_QOP_NONE;
      cycle_req = MMS_BC_NONE;
      seg_sel = MMS_SG_EXTRA;
      step(5);
      sys_rst = 1'b0;
      chk({qs, ct[1], ct[0]}, 4'h3);
      chk({sg, fixed_zero_status, status_oe}, 4'h9);
      t_queue();
      t_cycle();
      t_halt();
      t_esc();
      t_reset();
      give_verdict();
   end
endmodule : testbench
